// ===== rtl/bf_pkg.sv
// Constants and types for the breaker failure supervision block
// Notes on behaviour
// R1 - Scheme picks current, position or both
// R2 - Current scheme: trip if current persists
// R3 - Position scheme: trip if not shown open
// R4 - Combined: trip only if both fail
// R5 - Timer keeps running after trigger drops
// R6 - Expiry without opening asserts backup trip
// R7 - Confirmed opening stops the timer
// R8 - Opening with trigger active means rejected
// R9 - Rejected holds while trigger stays, no retime
// R10 - All triggers gone returns to standby
// R11 - Lockout sets with the backup trip
// R12 - Lockout latched until acknowledge input
// R13 - Trigger mode selects trip sources
// R14 - Three extra start inputs always usable
// R15 - Mode none: only extra inputs start
// R16 - Triggers evaluated only enabled, unblocked
// R17 - Supervision time exceeds total clearing time
// R18 - Any phase at threshold means current flows
// R19 - Waiting and running flags exclusive
// R20 - Start is OR of sources and extras
package bf_pkg;
    localparam int unsigned CUR_W = 16;
    localparam int unsigned TMR_W = 24;
    localparam logic [1:0] SCHEME_CURRENT = 2'h0;
    localparam logic [1:0] SCHEME_POSITION = 2'h1;
    localparam logic [1:0] SCHEME_COMBINED = 2'h2;
    localparam logic [1:0] TRIG_ALL = 2'h0;
    localparam logic [1:0] TRIG_EXTERNAL = 2'h1;
    localparam logic [1:0] TRIG_CURRENT = 2'h2;
    localparam logic [1:0] TRIG_NONE = 2'h3;
    localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
    localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;
    localparam logic [2:0] SYNC_RST = 3'h0;
    // Avalon register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TIME = 4'h4;
    localparam logic [3:0] ADDR_THRESH = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    // Control register fields
    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_SCHEME_LO = 1;
    localparam int unsigned CTRL_TRIG_LO = 3;
    localparam int unsigned CTRL_ACK = 5;
    localparam logic [31:0] READ_ZERO = 32'h00000000;
    localparam logic [TMR_W-1:0] TIME_RESET = 24'h00FFFF;
    localparam logic [CUR_W-1:0] THRESH_RESET = 16'h0100;
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_RUNNING = 2'b01,
        ST_TRIPPED = 2'b11,
        ST_REJECTED = 2'b10
    } bf_state_t;
endpackage : bf_pkg

// ===== rtl/breaker_failure_unit.sv
// Breaker failure supervision with Avalon-MM register slave
module breaker_failure_unit
    import bf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [CUR_W-1:0] phase_current_a,
    input wire logic [CUR_W-1:0] phase_current_b,
    input wire logic [CUR_W-1:0] phase_current_c,
    input wire logic breaker_open_pin,
    input wire logic block_pin,
    input wire logic lockout_reset_pin,
    input wire logic every_assigned_trip_source,
    input wire logic external_trip_source,
    input wire logic overcurrent_trip_source,
    input wire logic extra_start_input_1,
    input wire logic extra_start_input_2,
    input wire logic extra_start_input_3,
    output logic failure_alarm,
    output logic lockout_latch,
    output logic timer_running_flag,
    output logic idle_waiting_flag,
    output logic rejected_flag
);
    typedef struct packed {
        bf_state_t st;
        logic [TMR_W-1:0] tmr;
        logic alarm;
        logic lock;
        logic enable;
        logic [1:0] scheme;
        logic [1:0] trig_mode;
        logic [TMR_W-1:0] sup_time;
        logic [CUR_W-1:0] thresh;
        logic [2:0] s_open;
        logic [2:0] s_blk;
        logic [2:0] s_rst;
        logic open_lvl;
        logic blk_lvl;
        logic rst_lvl;
        logic [31:0] rdata;
        logic wait_n;
        logic run;
        logic idle;
        logic rej;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic open_q;
    logic blk_q;
    logic rst_q;
    logic current_flows;
    logic pos_open;
    logic confirmed;
    logic start;
    logic mode_src;
    logic ack_wr;
    logic access;
    logic commit;

    // Pin levels taken from the filtered stage pairs
    always_comb
    begin
        open_q = state_reg.open_lvl;
        blk_q = state_reg.blk_lvl;
        rst_q = state_reg.rst_lvl;
    end

    // R18 any phase flowing
    assign current_flows = (phase_current_a >= state_reg.thresh)
        | (phase_current_b >= state_reg.thresh)
        | (phase_current_c >= state_reg.thresh);
    assign pos_open = open_q;

    // R1 scheme selects confirmation
    always_comb
    begin
        case (state_reg.scheme)
            SCHEME_CURRENT: confirmed = ~current_flows;
            SCHEME_POSITION: confirmed = pos_open;
            // R4 combined needs both failing
            SCHEME_COMBINED: confirmed = ~current_flows | pos_open;
            default: confirmed = ~current_flows;
        endcase
    end

    // R13 trip source selection
    always_comb
    begin
        case (state_reg.trig_mode)
            TRIG_ALL: mode_src = every_assigned_trip_source;
            TRIG_EXTERNAL: mode_src = external_trip_source;
            TRIG_CURRENT: mode_src = overcurrent_trip_source;
            // R15 none leaves extras only
            default: mode_src = 1'b0;
        endcase
    end

    // R20 combined start, R14 extras, R16 gating
    assign start = state_reg.enable & ~blk_q & (mode_src | extra_start_input_1
        | extra_start_input_2 | extra_start_input_3);

    // Accept on the first edge, writes land on the edge with waitrequest low
    assign access = (avs_read | avs_write) & ~state_reg.wait_n;
    assign commit = avs_write & state_reg.wait_n;
    assign ack_wr = commit & (avs_address == ADDR_CTRL)
        & avs_writedata[CTRL_ACK];

    // Next state: sync chains, supervision sequencer, registers
    always_comb
    begin
        state_next = state_reg;
        state_next.s_open = {state_reg.s_open[1:0], breaker_open_pin};
        state_next.s_blk = {state_reg.s_blk[1:0], block_pin};
        state_next.s_rst = {state_reg.s_rst[1:0], lockout_reset_pin};
        // A pin level moves only once stages two and three agree
        if (state_reg.s_open[1] == state_reg.s_open[2])
            state_next.open_lvl = state_reg.s_open[2];
        if (state_reg.s_blk[1] == state_reg.s_blk[2])
            state_next.blk_lvl = state_reg.s_blk[2];
        if (state_reg.s_rst[1] == state_reg.s_rst[2])
            state_next.rst_lvl = state_reg.s_rst[2];
        case (state_reg.st)
            ST_STANDBY:
            begin
                if (start)
                begin
                    state_next.st = ST_RUNNING;
                    state_next.tmr = state_reg.sup_time;
                end
            end
            ST_RUNNING:
            begin
                // R7 opening stops timer
                if (confirmed)
                begin
                    // R8 rejected if still triggered, R10 else standby
                    state_next.st = start ? ST_REJECTED : ST_STANDBY;
                end
                // R6 expiry gives backup trip, R2 R3 R4
                else if (state_reg.tmr <= TMR_ONE)
                begin
                    state_next.st = ST_TRIPPED;
                    state_next.alarm = 1'b1;
                    // R11 lockout with trip
                    state_next.lock = 1'b1;
                    state_next.tmr = TMR_ZERO;
                end
                else
                begin
                    // R5 counts regardless of trigger
                    state_next.tmr = state_reg.tmr - TMR_ONE;
                end
            end
            ST_TRIPPED:
            begin
                if (!start)
                begin
                    state_next.st = ST_STANDBY;
                    state_next.alarm = 1'b0;
                end
            end
            ST_REJECTED:
            begin
                // R9 hold without retiming, R10 release
                if (!start)
                begin
                    state_next.st = ST_STANDBY;
                end
            end
            default: state_next.st = ST_STANDBY;
        endcase
        // R19 one status flag each for standby, running and rejected, none for tripped, registered
        state_next.run = state_next.st == ST_RUNNING;
        state_next.idle = state_next.st == ST_STANDBY;
        state_next.rej = state_next.st == ST_REJECTED;
        // R12 only acknowledge clears, trip set wins
        if ((rst_q | ack_wr) && !(state_next.alarm && !state_reg.alarm))
        begin
            state_next.lock = 1'b0;
        end
        // Avalon slave: one wait cycle, read answer loaded on first edge, write lands on second
        state_next.wait_n = access;
        state_next.rdata = READ_ZERO;
        if (access && avs_read)
        begin
            case (avs_address)
                ADDR_CTRL: state_next.rdata = {26'h0000000, 1'b0, state_reg.trig_mode,
                    state_reg.scheme, state_reg.enable};
                ADDR_TIME: state_next.rdata = {8'h00, state_reg.sup_time};
                ADDR_THRESH: state_next.rdata = {16'h0000, state_reg.thresh};
                ADDR_STATUS: state_next.rdata = {27'h0000000, state_reg.st == ST_REJECTED,
                    state_reg.st == ST_STANDBY, state_reg.st == ST_RUNNING,
                    state_reg.lock, state_reg.alarm};
                default: state_next.rdata = READ_ZERO;
            endcase
        end
        if (commit)
        begin
            case (avs_address)
                ADDR_CTRL:
                begin
                    state_next.enable = avs_writedata[CTRL_ENABLE];
                    state_next.scheme = avs_writedata[CTRL_SCHEME_LO +: 2];
                    state_next.trig_mode = avs_writedata[CTRL_TRIG_LO +: 2];
                end
                ADDR_TIME: state_next.sup_time = avs_writedata[TMR_W-1:0];
                ADDR_THRESH: state_next.thresh = avs_writedata[CUR_W-1:0];
                default: state_next.thresh = state_next.thresh;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg.st <= ST_STANDBY;
            state_reg.tmr <= TMR_ZERO;
            state_reg.alarm <= 1'b0;
            state_reg.lock <= 1'b0;
            state_reg.enable <= 1'b0;
            state_reg.scheme <= SCHEME_CURRENT;
            state_reg.trig_mode <= TRIG_ALL;
            state_reg.sup_time <= TIME_RESET;
            state_reg.thresh <= THRESH_RESET;
            state_reg.s_open <= SYNC_RST;
            state_reg.s_blk <= SYNC_RST;
            state_reg.s_rst <= SYNC_RST;
            state_reg.rdata <= READ_ZERO;
            state_reg.wait_n <= 1'b0;
            state_reg.open_lvl <= 1'b0;
            state_reg.blk_lvl <= 1'b0;
            state_reg.rst_lvl <= 1'b0;
            state_reg.run <= 1'b0;
            state_reg.idle <= 1'b1;
            state_reg.rej <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata = state_reg.rdata;
    assign avs_waitrequest = ~state_reg.wait_n;
    assign failure_alarm = state_reg.alarm;
    assign lockout_latch = state_reg.lock;
    assign timer_running_flag = state_reg.run;
    assign idle_waiting_flag = state_reg.idle;
    assign rejected_flag = state_reg.rej;

    // R6 trip follows expiry
    sequence expiry_s;
        timer_running_flag && !confirmed && state_reg.tmr == TMR_ONE;
    endsequence
    trip_on_expiry_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
        expiry_s |=> failure_alarm && lockout_latch)
        else $error("backup trip missing at expiry");
    // R11 lockout with trip
    lock_with_trip_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
        $rose(failure_alarm) |-> lockout_latch)
        else $error("lockout not set with trip");
    // R12 lockout held
    lock_held_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
        lockout_latch && !rst_q && !ack_wr |=> lockout_latch)
        else $error("lockout dropped without acknowledge");
    // R19 exclusive flags
    flags_exclusive_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R19
        $onehot0({timer_running_flag, idle_waiting_flag, rejected_flag}))
        else $error("status flags overlap");
    // R7 stop on opening
    stop_on_open_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
        timer_running_flag && confirmed |=> !timer_running_flag && !failure_alarm)
        else $error("timer not stopped on opening");
    // R9 rejected holds
    rejected_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
        rejected_flag && start |=> rejected_flag)
        else $error("rejected state left while triggered");
    // R16 blocked gives no start
    no_start_blk_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
        idle_waiting_flag && (blk_q || !state_reg.enable) |=> !timer_running_flag)
        else $error("start while blocked or disabled");
    // R5 timer keeps counting
    keeps_running_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
        timer_running_flag && !confirmed && state_reg.tmr > TMR_ONE
        |=> timer_running_flag && state_reg.tmr == $past(state_reg.tmr) - TMR_ONE)
        else $error("timer stalled");
    // R2 R3 R4 opening seen per scheme
    sequence current_clear_s;
        timer_running_flag && state_reg.scheme == SCHEME_CURRENT && !current_flows;
    endsequence
    sequence position_clear_s;
        timer_running_flag && state_reg.scheme == SCHEME_POSITION && pos_open;
    endsequence
    sequence combined_clear_s;
        timer_running_flag && state_reg.scheme == SCHEME_COMBINED
            && (pos_open || !current_flows);
    endsequence
    current_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
        current_clear_s |=> !failure_alarm && !timer_running_flag)
        else $error("current scheme missed the opening");
    position_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
        position_clear_s |=> !failure_alarm && !timer_running_flag)
        else $error("position scheme missed the opening");
    combined_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
        combined_clear_s |=> !failure_alarm && !timer_running_flag)
        else $error("combined scheme missed the opening");
    // R8 opening while triggered
    reject_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
        timer_running_flag && confirmed && start |=> rejected_flag)
        else $error("rejected state not entered");
    // R9 no retiming from rejected
    no_retime_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
        rejected_flag |=> !timer_running_flag)
        else $error("timer restarted from rejected state");
    // R10 standby once triggers drop
    standby_return_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
        (rejected_flag || state_reg.st == ST_TRIPPED) && !start |=> idle_waiting_flag)
        else $error("standby not reached after triggers dropped");
    // R12 acknowledge clears lockout
    ack_clears_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
        lockout_latch && (rst_q || ack_wr) && !timer_running_flag |=> !lockout_latch)
        else $error("lockout kept after acknowledge");
    // R13 external source starts
    external_start_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
        idle_waiting_flag && state_reg.enable && !blk_q
            && state_reg.trig_mode == TRIG_EXTERNAL && external_trip_source
            |=> timer_running_flag)
        else $error("external source did not start timer");
    // R14 extra inputs start
    extra_start_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
        idle_waiting_flag && state_reg.enable && !blk_q
            && (extra_start_input_1 || extra_start_input_2 || extra_start_input_3)
            |=> timer_running_flag)
        else $error("extra input did not start timer");
    // R15 mode none ignores sources
    none_mode_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
        idle_waiting_flag && state_reg.trig_mode == TRIG_NONE
            && !(extra_start_input_1 || extra_start_input_2 || extra_start_input_3)
            |=> !timer_running_flag)
        else $error("trip source started timer in mode none");
    // R5 running after trigger drops
    run_after_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
        timer_running_flag && !start && !confirmed && state_reg.tmr > TMR_ONE
            |=> timer_running_flag)
        else $error("timer stopped when trigger dropped");
endmodule : breaker_failure_unit

// ===== tb/breaker_model.sv
// Behavioural breaker: main contacts, position contact and phase current sensing
module breaker_model
    import bf_pkg::*;
#(
    parameter int OPEN_DELAY = 3
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic open_cmd,
    input wire logic stuck_current,
    input wire logic stuck_position,
    input wire logic [1:0] hot_phase,
    input wire logic [CUR_W-1:0] load,
    output logic [CUR_W-1:0] phase_current_a,
    output logic [CUR_W-1:0] phase_current_b,
    output logic [CUR_W-1:0] phase_current_c,
    output logic breaker_open_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int count;
    logic opened;
    logic [CUR_W-1:0] base;
    logic [CUR_W-1:0] hot;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 0;
            opened <= 1'b0;
        end
        else if (!open_cmd)
        begin
            count <= 0;
            opened <= 1'b0; // Recloses for the next case
        end
        else if (count < OPEN_DELAY)
            count <= count + 1;
        else
            opened <= 1'b1;
    end
    // A stuck pole keeps carrying load; a stuck contact never shows open
    assign base = (opened && !stuck_current) ? 16'h0000 : 16'h0010;
    assign hot = (opened && !stuck_current) ? 16'h0000 : load;
    assign phase_current_a = (hot_phase == 2'h0) ? hot : base;
    assign phase_current_b = (hot_phase == 2'h1) ? hot : base;
    assign phase_current_c = (hot_phase == 2'h2) ? hot : base;
    assign breaker_open_pin = opened && !stuck_position;
endmodule : breaker_model

// ===== tb/test_breaker_failure_unit.sv
// Self-checking bench for the breaker failure unit
module test_breaker_failure_unit
    import bf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 20;
    logic sys_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd;
    logic avs_waitrequest, open_pin, block_pin = 1'b0, ack_pin = 1'b0;
    logic [CUR_W-1:0] pa, pb, pc, load = 16'h0100;
    logic [2:0] src = 3'h0, ext = 3'h0;
    logic stuck_c = 1'b0, stuck_p = 1'b0, alarm, lock, run, idle, rej;
    logic [1:0] hot = 2'h2;
    int errors = 0, comparisons = 0;
    // Clock at 25 MHz
    initial
    begin
        forever #20ns sys_clk = ~sys_clk;
    end
    breaker_failure_unit breaker_failure_unit_i (.sys_clk(sys_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .phase_current_a(pa), .phase_current_b(pb),
        .phase_current_c(pc), .breaker_open_pin(open_pin), .block_pin(block_pin),
        .lockout_reset_pin(ack_pin), .every_assigned_trip_source(src[0]),
        .external_trip_source(src[1]), .overcurrent_trip_source(src[2]),
        .extra_start_input_1(ext[0]), .extra_start_input_2(ext[1]),
        .extra_start_input_3(ext[2]), .failure_alarm(alarm), .lockout_latch(lock),
        .timer_running_flag(run), .idle_waiting_flag(idle), .rejected_flag(rej));
    breaker_model #(.OPEN_DELAY(6)) breaker_model_i (.sys_clk(sys_clk), .nrst(nrst),
        .open_cmd(|{src, ext}), .stuck_current(stuck_c), .stuck_position(stuck_p),
        .hot_phase(hot), .load(load), .phase_current_a(pa), .phase_current_b(pb),
        .phase_current_c(pc), .breaker_open_pin(open_pin));
    task automatic results();
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
        comparisons++;
        if (got !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, e, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string name);
        bus(1'b0, a, 32'h00000000);
        chk(name, e, rd);
    endtask : rdchk
    task automatic cfg(input logic [1:0] s, input logic [1:0] m);
        wr(ADDR_CTRL, {27'h0, m, s, 1'b1});
    endtask : cfg
    // Flags as alarm, lockout, running, waiting, rejected
    task automatic flags(input logic [4:0] e);
        chk("flags", {27'h0, e}, {27'h0, alarm, lock, run, idle, rej});
    endtask : flags
    task automatic no_start();
        src[0] <= 1'b1;
        cyc(4);
        chk("waiting", 32'h00000001, {31'h0, idle});
        src[0] <= 1'b0;
        cyc(2);
    endtask : no_start
    // Start, watch expiry or rejection, drop the start, then acknowledge after a trip
    task automatic trip_case(input logic [1:0] s, input logic sc, input logic sp, input logic f);
        cfg(s, TRIG_ALL);
        stuck_c <= sc;
        stuck_p <= sp;
        src[0] <= 1'b1;
        do @(posedge sys_clk); while (run !== 1'b1 && rej !== 1'b1);
        if (f)
            rdchk(ADDR_STATUS, 32'h00000004, "status");
        else
            cyc(3);
        cyc(T - 5);
        flags(f ? 5'h04 : 5'h01);
        cyc(3);
        flags(f ? 5'h18 : 5'h01);
        src[0] <= 1'b0;
        cyc(3);
        flags(f ? 5'h0A : 5'h02);
        if (f && s == SCHEME_POSITION)
        begin
            ack_pin <= 1'b1;
            cyc(5);
            ack_pin <= 1'b0;
            cyc(2);
        end
        else if (f)
            wr(ADDR_CTRL, {26'h0, 1'b1, TRIG_ALL, s, 1'b1});
        flags(5'h02);
    endtask : trip_case
    // Main sequence
    initial
    begin
        cyc(12);
        nrst <= 1'b1;
        rdchk(ADDR_CTRL, 32'h00000000, "ctrl");
        rdchk(ADDR_TIME, 32'h0000FFFF, "time");
        rdchk(ADDR_THRESH, 32'h00000100, "thresh");
        rdchk(ADDR_STATUS, 32'h00000008, "status");
        wr(4'h2, 32'hFFFFFFFF);
        rdchk(4'h2, 32'h00000000, "unmapped");
        wr(ADDR_TIME, 32'(T));
        rdchk(ADDR_TIME, 32'(T), "time");
        trip_case(SCHEME_CURRENT, 1'b1, 1'b0, 1'b1);
        trip_case(SCHEME_CURRENT, 1'b0, 1'b1, 1'b0);
        trip_case(SCHEME_POSITION, 1'b0, 1'b1, 1'b1);
        trip_case(SCHEME_POSITION, 1'b1, 1'b0, 1'b0);
        trip_case(SCHEME_COMBINED, 1'b1, 1'b1, 1'b1);
        trip_case(SCHEME_COMBINED, 1'b1, 1'b0, 1'b0);
        trip_case(SCHEME_COMBINED, 1'b0, 1'b1, 1'b0);
        hot <= 2'h0;
        load <= 16'h00FF;
        trip_case(SCHEME_CURRENT, 1'b1, 1'b0, 1'b0);
        hot <= 2'h2;
        load <= 16'h0100;
        cfg(SCHEME_CURRENT, TRIG_NONE);
        rdchk(ADDR_CTRL, 32'h00000019, "ctrl");
        ext[2] <= 1'b1;
        cyc(2);
        ext[2] <= 1'b0;
        cyc(T + 2);
        chk("lockout", 32'h00000001, {31'h0, lock});
        wr(ADDR_CTRL, {26'h0, 1'b1, TRIG_NONE, SCHEME_CURRENT, 1'b1});
        chk("lockout", 32'h00000000, {31'h0, lock});
        stuck_c <= 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            cfg(SCHEME_CURRENT, 2'(m));
            for (int i = 0; i < 6; i++)
            begin
                {ext, src} <= 6'h01 << i;
                cyc(10);
                chk("waiting", {31'h0, !(i > 2 || (m < 3 && m == i))}, {31'h0, idle});
                {ext, src} <= 6'h00;
                cyc(4);
            end
        end
        wr(ADDR_CTRL, 32'h00000000);
        no_start();
        cfg(SCHEME_CURRENT, TRIG_ALL);
        block_pin <= 1'b1;
        cyc(6);
        no_start();
        results();
    end
    // Watchdog against a hung handshake
    initial
    begin
        #200000ns;
        errors++;
        results();
    end
endmodule : test_breaker_failure_unit
